// ---- inc/t1pc_pkg.sv ----
// types shared by the counter bank files
package t1pc_pkg;

  typedef enum logic {
    T1PC_FMT_D4 = 1'b0,
    T1PC_FMT_ESF = 1'b1
  } t1pc_format_type;

  // control register layout, bit 0 upward from the right
  typedef struct packed {
    logic [4:0] unused;
    logic fs_monitor_en;
    t1pc_format_type format;
    logic excess_zeros_select;
  } t1pc_ctrl_type;

  // events from the framer and line receiver, all on pclk
  typedef struct packed {
    logic frame_sync;
    logic multiframe_sync;
    logic fbit_strobe;
    logic fbit_err;
    logic fs_err;
    logic realign;
    logic bipolar_violation;
    logic excess_zero;
    logic crc6_err;
    logic message_start;
    logic message_stop;
    logic all_ones;
    logic signal_loss;
    logic tx_slip;
    logic rx_slip;
  } t1pc_events_type;

endpackage

// ---- inc/t1pc_regs.svh ----
// register indices, field positions, reset values and timing counts of the counter bank
`ifndef T1PC_REGS_SVH
`define T1PC_REGS_SVH

// ****************************************************************
// register indices (byte address = 4 * index)
// ****************************************************************
`define T1PC_IDX_FE 10'h013
`define T1PC_IDX_FLRA 10'h014
`define T1PC_IDX_MFOOF 10'h015
`define T1PC_IDX_LCVH 10'h016
`define T1PC_IDX_LCVL 10'h017
`define T1PC_IDX_CRCH 10'h018
`define T1PC_IDX_CRCL 10'h019
`define T1PC_IDX_EFW0 10'h01b
`define T1PC_IDX_CTRL 10'h020
`define T1PC_IDX_MASK 10'h021
`define T1PC_IDX_OVFL 10'h022

// ****************************************************************
// event flag word zero bit positions
// ****************************************************************
`define T1PC_EF_TFSYN 7
`define T1PC_EF_MFSYN 6
`define T1PC_EF_MSG 5
`define T1PC_EF_AIS 4
`define T1PC_EF_LOS 3
`define T1PC_EF_SEV 2
`define T1PC_EF_TXSLIP 1
`define T1PC_EF_RXSLIP 0

// ****************************************************************
// overflow latch bit positions
// ****************************************************************
`define T1PC_OV_FE 7
`define T1PC_OV_CRC 6
`define T1PC_OV_OOF 5
`define T1PC_OV_COFA 4
`define T1PC_OV_LCV 3
`define T1PC_OV_MFOOF 0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define T1PC_CTRL_RST 8'h00
`define T1PC_MASK_RST 8'hff
`define T1PC_EFW0_RC_MASK 8'hdf
`define T1PC_OVFL_USED 8'hf9

// ****************************************************************
// timing
// ****************************************************************
`define T1PC_CLK_MHZ 10
`define T1PC_MF_D4_US 1500
`define T1PC_MF_ESF_US 3000
`define T1PC_MF_D4_CYC (`T1PC_MF_D4_US * `T1PC_CLK_MHZ)
`define T1PC_MF_ESF_CYC (`T1PC_MF_ESF_US * `T1PC_CLK_MHZ)
`define T1PC_SEV_WIN 6

`endif

// ---- logic/t1pc_top.sv ----
// performance counters and event flag word zero of a t1 receiver, apb register port
`timescale 1ns/1ps
`default_nettype none
`include "t1pc_regs.svh"

// Summary of operation
// - eight-bit framing error counter counts each received framing pattern error
// - esf counts esf framing bits; d4 counts terminal, optionally signalling bits
// - framing errors counted only while in frame sync
// - upper nibble counts each loss of receive frame sync
// - lower nibble counts each resync that shifts frame alignment
// - eight-bit counter counts multiframes (1.5/3 ms) with sync lost
// - sixteen-bit line violation counter, high byte then low byte addresses
// - excess zeros select low: count only non-substitution bipolar violations
// - excess zeros select high: count bipolar violations and excess zeros
// - sixteen-bit crc-6 error counter, high byte then low byte addresses
// - flag bit 7 on terminal frame sync change when unmasked
// - flag bit 6 on multiframe sync change when unmasked
// - flag bit 5 on message arrival or stop when unmasked
// - flag bit 4 on all-ones condition change when unmasked
// - flag bit 3 on loss of signal change when unmasked
// - flag bit 2 on two framing errors within six framing bits
// - flag bit 1 on transmit elastic buffer slip
// - flag bit 0 on receive elastic buffer slip
// - reading the flag word clears latched bits, except message bit
// - counters wrap all ones to zero and raise an overflow indication
module t1pc_top
  import t1pc_pkg::*;
#(
  parameter int MF_D4_CYCLES = `T1PC_MF_D4_CYC,
  parameter int MF_ESF_CYCLES = `T1PC_MF_ESF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire t1pc_events_type ev
);

  localparam logic [15:0] MF_D4_LAST = 16'(MF_D4_CYCLES - 1);
  localparam logic [15:0] MF_ESF_LAST = 16'(MF_ESF_CYCLES - 1);
  localparam int SEV_HIST = `T1PC_SEV_WIN - 1;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [9:0] idx;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign rd_acc = psel & penable & pready_r & ~pwrite & ~pslverr_r;

  // ****************************************************************
  // software registers
  // ****************************************************************
  t1pc_ctrl_type ctrl_r;
  logic [7:0] mask_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= t1pc_ctrl_type'(`T1PC_CTRL_RST);
    end else if (wr_acc && idx == `T1PC_IDX_CTRL) begin
      ctrl_r <= t1pc_ctrl_type'({5'h00, pwdata[2:0]});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `T1PC_MASK_RST;
    end else if (wr_acc && idx == `T1PC_IDX_MASK) begin
      mask_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // level history for change detection
  // ****************************************************************
  logic prime_r;
  logic sync_q;
  logic mfsync_q;
  logic ais_q;
  logic los_q;

  // first cycle after reset only loads the history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prime_r <= 1'b0;
      sync_q <= 1'b0;
      mfsync_q <= 1'b0;
      ais_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      prime_r <= 1'b1;
      sync_q <= ev.frame_sync;
      mfsync_q <= ev.multiframe_sync;
      ais_q <= ev.all_ones;
      los_q <= ev.signal_loss;
    end
  end

  // ****************************************************************
  // counter increments
  // ****************************************************************
  logic fe_inc;
  logic oof_inc;
  logic cofa_inc;
  logic lcv_inc;
  logic crc_inc;
  logic mfoof_inc;
  logic fs_counted;

  assign fs_counted = (ctrl_r.format == T1PC_FMT_D4) & ctrl_r.fs_monitor_en & ev.fs_err;
  assign fe_inc = ev.frame_sync & (ev.fbit_err | fs_counted);
  assign oof_inc = prime_r & sync_q & ~ev.frame_sync;
  assign cofa_inc = ev.realign;
  assign lcv_inc = ev.bipolar_violation | (ctrl_r.excess_zeros_select & ev.excess_zero);
  assign crc_inc = ev.crc6_err;

  // ****************************************************************
  // multiframe timer
  // ****************************************************************
  logic [15:0] mf_cnt_r;
  logic [15:0] mf_last;
  logic mf_tick;
  logic mf_lost_r;

  assign mf_last = (ctrl_r.format == T1PC_FMT_ESF) ? MF_ESF_LAST : MF_D4_LAST;
  assign mf_tick = (mf_cnt_r >= mf_last);
  assign mfoof_inc = mf_tick & (mf_lost_r | ~ev.frame_sync);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_cnt_r <= 16'h0000;
    end else if (mf_tick) begin
      mf_cnt_r <= 16'h0000;
    end else begin
      mf_cnt_r <= mf_cnt_r + 16'h0001;
    end
  end

  // remembers any loss of sync within the running multiframe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_lost_r <= 1'b0;
    end else if (mf_tick) begin
      mf_lost_r <= 1'b0;
    end else if (!ev.frame_sync) begin
      mf_lost_r <= 1'b1;
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  logic [7:0] fe_count;
  logic [3:0] oof_count;
  logic [3:0] cofa_count;
  logic [7:0] mfoof_count;
  logic [15:0] lcv_count;
  logic [15:0] crc_count;
  logic fe_wrap;
  logic oof_wrap;
  logic cofa_wrap;
  logic mfoof_wrap;
  logic lcv_wrap;
  logic crc_wrap;

  t1pc_wrap_counter #(.WIDTH(8)) u_fe (
    .pclk(pclk),
    .presetn(presetn),
    .inc(fe_inc),
    .count(fe_count),
    .wrap(fe_wrap)
  );

  t1pc_wrap_counter #(.WIDTH(4)) u_oof (
    .pclk(pclk),
    .presetn(presetn),
    .inc(oof_inc),
    .count(oof_count),
    .wrap(oof_wrap)
  );

  t1pc_wrap_counter #(.WIDTH(4)) u_cofa (
    .pclk(pclk),
    .presetn(presetn),
    .inc(cofa_inc),
    .count(cofa_count),
    .wrap(cofa_wrap)
  );

  t1pc_wrap_counter #(.WIDTH(8)) u_mfoof (
    .pclk(pclk),
    .presetn(presetn),
    .inc(mfoof_inc),
    .count(mfoof_count),
    .wrap(mfoof_wrap)
  );

  t1pc_wrap_counter #(.WIDTH(16)) u_lcv (
    .pclk(pclk),
    .presetn(presetn),
    .inc(lcv_inc),
    .count(lcv_count),
    .wrap(lcv_wrap)
  );

  t1pc_wrap_counter #(.WIDTH(16)) u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .inc(crc_inc),
    .count(crc_count),
    .wrap(crc_wrap)
  );

  // ****************************************************************
  // severely errored framing window
  // ****************************************************************
  logic [SEV_HIST-1:0] fbit_hist_r;
  logic sev_event;

  // current framing bit plus the five before it
  assign sev_event = ev.fbit_strobe & ev.fbit_err & (|fbit_hist_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fbit_hist_r <= '0;
    end else if (ev.fbit_strobe) begin
      fbit_hist_r <= {fbit_hist_r[SEV_HIST-2:0], ev.fbit_err};
    end
  end

  // ****************************************************************
  // event flag word zero
  // ****************************************************************
  logic [7:0] ef_set;
  logic [7:0] ef_clr;
  logic [7:0] efw0_r;

  always_comb begin
    ef_set = 8'h00;
    ef_set[`T1PC_EF_TFSYN] = prime_r & (sync_q ^ ev.frame_sync);
    ef_set[`T1PC_EF_MFSYN] = prime_r & (mfsync_q ^ ev.multiframe_sync);
    ef_set[`T1PC_EF_MSG] = ev.message_start | ev.message_stop;
    ef_set[`T1PC_EF_AIS] = prime_r & (ais_q ^ ev.all_ones);
    ef_set[`T1PC_EF_LOS] = prime_r & (los_q ^ ev.signal_loss);
    ef_set[`T1PC_EF_SEV] = sev_event;
    ef_set[`T1PC_EF_TXSLIP] = ev.tx_slip;
    ef_set[`T1PC_EF_RXSLIP] = ev.rx_slip;
    ef_set = ef_set & mask_r;
  end

  // only bits that the read actually returned are cleared
  always_comb begin
    ef_clr = 8'h00;
    if (rd_acc && idx == `T1PC_IDX_EFW0) begin
      ef_clr = prdata_r[7:0] & `T1PC_EFW0_RC_MASK;
    end
    if (wr_acc && idx == `T1PC_IDX_EFW0) begin
      ef_clr[`T1PC_EF_MSG] = pwdata[`T1PC_EF_MSG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      efw0_r <= 8'h00;
    end else begin
      efw0_r <= (efw0_r & ~ef_clr) | ef_set;
    end
  end

  // ****************************************************************
  // overflow latch
  // ****************************************************************
  logic [7:0] ov_set;
  logic [7:0] ov_clr;
  logic [7:0] ovfl_r;

  always_comb begin
    ov_set = 8'h00;
    ov_set[`T1PC_OV_FE] = fe_wrap;
    ov_set[`T1PC_OV_CRC] = crc_wrap;
    ov_set[`T1PC_OV_OOF] = oof_wrap;
    ov_set[`T1PC_OV_COFA] = cofa_wrap;
    ov_set[`T1PC_OV_LCV] = lcv_wrap;
    ov_set[`T1PC_OV_MFOOF] = mfoof_wrap;
    ov_clr = 8'h00;
    if (rd_acc && idx == `T1PC_IDX_OVFL) begin
      ov_clr = prdata_r[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovfl_r <= 8'h00;
    end else begin
      ovfl_r <= (ovfl_r & ~ov_clr) | ov_set;
    end
  end

  // ****************************************************************
  // read mux and apb answer
  // ****************************************************************
  logic [7:0] rd_mux;
  logic rd_hit;

  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    case (idx)
      `T1PC_IDX_FE: rd_mux = fe_count;
      `T1PC_IDX_FLRA: rd_mux = {oof_count, cofa_count};
      `T1PC_IDX_MFOOF: rd_mux = mfoof_count;
      `T1PC_IDX_LCVH: rd_mux = lcv_count[15:8];
      `T1PC_IDX_LCVL: rd_mux = lcv_count[7:0];
      `T1PC_IDX_CRCH: rd_mux = crc_count[15:8];
      `T1PC_IDX_CRCL: rd_mux = crc_count[7:0];
      `T1PC_IDX_EFW0: rd_mux = efw0_r;
      `T1PC_IDX_CTRL: rd_mux = ctrl_r;
      `T1PC_IDX_MASK: rd_mux = mask_r;
      `T1PC_IDX_OVFL: rd_mux = ovfl_r & `T1PC_OVFL_USED;
      default: rd_hit = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle, so access always takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      pslverr_r <= ~rd_hit;
    end else if (!psel) begin
      pslverr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b1;
    end else begin
      pready_r <= 1'b1;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule

`default_nettype wire

// ---- logic/t1pc_wrap_counter.sv ----
// free running event counter that wraps to zero and flags the wrap
`timescale 1ns/1ps
`default_nettype none

module t1pc_wrap_counter #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic inc,
  output logic [WIDTH-1:0] count,
  output logic wrap
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (inc) begin
      count <= count + 1'b1;
    end
  end

  // all ones plus one gives zero
  assign wrap = inc & (&count);

endmodule

`default_nettype wire

// ---- verif/t1pc_top_monitor.sv ----
// checker of the counter bank port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "t1pc_regs.svh"
module t1pc_top_monitor
  import t1pc_pkg::*;
#(
  parameter int MF_D4_CYCLES = 20,
  parameter int MF_ESF_CYCLES = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire t1pc_events_type ev
);
  // ****
  // helpers
  // ****
  wire logic [9:0] ix = paddr[11:2];
  wire logic su = psel && !penable;
  wire logic rd = su && !pwrite;
  wire logic rdf = rd && ix == `T1PC_IDX_EFW0;
  wire logic mapped = (ix >= `T1PC_IDX_FE && ix <= `T1PC_IDX_CRCL) || ix == `T1PC_IDX_EFW0 ||
    (ix >= `T1PC_IDX_CTRL && ix <= `T1PC_IDX_OVFL);
  wire logic nofs = !ev.frame_sync;
  wire logic nolv = !ev.bipolar_violation && !ev.excess_zero;
  wire logic nocrc = !ev.crc6_err;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****
  // properties
  // ****
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_unmapped;
    su && !mapped |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped index");
  property p_mapped;
    su && mapped |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped index");
  property p_fs_clear;
    (rdf && $stable(ev.frame_sync)) ##1 (prdata[7] && $stable(ev.frame_sync))
      ##1 (rdf && $stable(ev.frame_sync)) |=> !prdata[7];
  endproperty
  a_fs_clear: assert property (p_fs_clear) else $error("sync flag kept after read");
  property p_msg_keep;
    rdf ##1 prdata[5] ##1 rdf |=> prdata[5];
  endproperty
  a_msg_keep: assert property (p_msg_keep) else $error("message flag lost");
  property p_fe_hold;
    (rd && ix == `T1PC_IDX_FE && nofs && $past(nofs) && $past(nofs, 2)) ##1 nofs
      ##1 (rd && ix == `T1PC_IDX_FE && nofs) |=> prdata == $past(prdata, 2);
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing count moved out of sync");
  property p_lcv_hold;
    (rd && ix == `T1PC_IDX_LCVL && nolv && $past(nolv) && $past(nolv, 2)) ##1 nolv
      ##1 (rd && ix == `T1PC_IDX_LCVL && nolv) |=> prdata == $past(prdata, 2);
  endproperty
  a_lcv_hold: assert property (p_lcv_hold) else $error("violation count moved");
  property p_crc_hold;
    (rd && ix == `T1PC_IDX_CRCL && nocrc && $past(nocrc) && $past(nocrc, 2)) ##1 nocrc
      ##1 (rd && ix == `T1PC_IDX_CRCL && nocrc) |=> prdata == $past(prdata, 2);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc count moved");
  c_unmapped: cover property (su && !mapped);
  c_flag: cover property (rdf ##1 prdata[7]);
  c_ovfl: cover property (rd && ix == `T1PC_IDX_OVFL ##1 prdata[7]);
endmodule
bind t1pc_top t1pc_top_monitor #(.MF_D4_CYCLES(MF_D4_CYCLES), .MF_ESF_CYCLES(MF_ESF_CYCLES)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev(ev));
`default_nettype wire

// ---- verif/tb_t1pc_top.sv ----
// self-checking bench of the counter bank
`timescale 1ns/1ps
`default_nettype none
`include "t1pc_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_t1pc_top import t1pc_pkg::*;;
  // ****
  // declarations
  // ****
  typedef struct {logic [7:0] c; logic [14:0] m; int n; logic [9:0] ix; logic [7:0] d;} t1pc_row_type;
  t1pc_row_type rows [9];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [14:0] lv;
  t1pc_events_type ev;
  logic [7:0] mdl [0:63];
  int err_total, compares, cyc;
  t1pc_top #(.MF_D4_CYCLES(20), .MF_ESF_CYCLES(40)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev(ev));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the cycle ceiling ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    penable <= 1'b0;
  endtask
  task automatic idle();
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 32'h0000_0000);
    `CHK($sformatf("reg %h", ix), {24'h00_0000, e}, rd_data)
  endtask
  task automatic pulse(input logic [14:0] m, input int n);
    repeat (n) begin
      ev <= t1pc_events_type'(lv ^ m);
      @(posedge pclk);
      ev <= t1pc_events_type'(lv);
      @(posedge pclk);
    end
  endtask
  task automatic strobes(input logic [7:0] e, input int n);
    for (int i = 0; i < n; i++) pulse(e[i] ? 15'h1800 : 15'h1000, 1);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lv = 15'h6000;
    ev = t1pc_events_type'(lv);
    err_total = 0;
    compares = 0;
    cyc = 0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    rows[0] = '{8'h00, 15'h0800, 3, `T1PC_IDX_FE, 8'h03};
    rows[1] = '{8'h04, 15'h0400, 2, `T1PC_IDX_FE, 8'h02};
    rows[2] = '{8'h06, 15'h0400, 2, `T1PC_IDX_FE, 8'h00};
    rows[3] = '{8'h00, 15'h0200, 5, `T1PC_IDX_FLRA, 8'h05};
    rows[4] = '{8'h00, 15'h0100, 4, `T1PC_IDX_LCVL, 8'h04};
    rows[5] = '{8'h00, 15'h0080, 4, `T1PC_IDX_LCVL, 8'h00};
    rows[6] = '{8'h01, 15'h0080, 3, `T1PC_IDX_LCVL, 8'h03};
    rows[7] = '{8'h01, 15'h0180, 2, `T1PC_IDX_LCVL, 8'h02};
    rows[8] = '{8'h00, 15'h0040, 5, `T1PC_IDX_CRCL, 8'h05};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[r]) begin
      apb(1'b1, `T1PC_IDX_CTRL, {24'h00_0000, rows[r].c});
      idle();
      pulse(rows[r].m, rows[r].n);
      mdl[rows[r].ix] += rows[r].d;
      rdc(rows[r].ix, mdl[rows[r].ix]);
      idle();
    end
    rdc(`T1PC_IDX_LCVL, mdl[`T1PC_IDX_LCVL]);
    rdc(`T1PC_IDX_LCVL, mdl[`T1PC_IDX_LCVL]);
    rdc(`T1PC_IDX_CRCL, mdl[`T1PC_IDX_CRCL]);
    rdc(`T1PC_IDX_CRCL, mdl[`T1PC_IDX_CRCL]);
    idle();
    $display("counter rows done");
    lv = 15'h400c;
    pulse(15'h0023, 1);
    rdc(`T1PC_IDX_EFW0, 8'h7b);
    rdc(`T1PC_IDX_EFW0, 8'h20);
    apb(1'b1, `T1PC_IDX_EFW0, 32'h0000_0020);
    idle();
    lv = 15'h6000;
    pulse(15'h0010, 1);
    rdc(`T1PC_IDX_EFW0, 8'h78);
    apb(1'b1, `T1PC_IDX_EFW0, 32'h0000_0020);
    rdc(`T1PC_IDX_EFW0, 8'h00);
    apb(1'b1, `T1PC_IDX_MASK, 32'h0000_0000);
    idle();
    pulse(15'h0002, 1);
    rdc(`T1PC_IDX_EFW0, 8'h00);
    apb(1'b1, `T1PC_IDX_MASK, 32'h0000_00ff);
    idle();
    $display("flag word done");
    strobes(8'h41, 7);
    rdc(`T1PC_IDX_EFW0, 8'h00);
    idle();
    strobes(8'h00, 6);
    strobes(8'h05, 3);
    rdc(`T1PC_IDX_EFW0, 8'h04);
    idle();
    mdl[`T1PC_IDX_FE] += 8'h04;
    $display("severe frame done");
    pulse(15'h4800, 1);
    repeat (25) @(posedge pclk);
    pulse(15'h4000, 1);
    repeat (45) @(posedge pclk);
    mdl[`T1PC_IDX_FLRA] += 8'h20;
    rdc(`T1PC_IDX_FE, mdl[`T1PC_IDX_FE]);
    rdc(`T1PC_IDX_FLRA, mdl[`T1PC_IDX_FLRA]);
    rdc(`T1PC_IDX_MFOOF, 8'h02);
    rdc(`T1PC_IDX_EFW0, 8'h80);
    rdc(`T1PC_IDX_EFW0, 8'h00);
    apb(1'b1, `T1PC_IDX_FE, 32'h0000_0055);
    rdc(`T1PC_IDX_FE, mdl[`T1PC_IDX_FE]);
    apb(1'b0, 10'h01a, 32'h0000_0000);
    idle();
    `CHK("slverr", 1'b1, rd_err)
    $display("frame loss done");
    pulse(15'h0800, 256 - mdl[`T1PC_IDX_FE]);
    rdc(`T1PC_IDX_FE, 8'h00);
    rdc(`T1PC_IDX_OVFL, 8'h01 << `T1PC_OV_FE);
    rdc(`T1PC_IDX_OVFL, 8'h00);
    idle();
    lv = 15'h2800;
    ev <= t1pc_events_type'(lv);
    repeat (3) @(posedge pclk);
    rdc(`T1PC_IDX_FE, 8'h00);
    rdc(`T1PC_IDX_FE, 8'h00);
    idle();
    $display("wrap done");
    lv = 15'h6000;
    ev <= t1pc_events_type'(lv);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = `T1PC_IDX_FE; a <= `T1PC_IDX_OVFL; a++) begin
      if (a != 10'h01a && (a < 10'h01c || a > 10'h01f))
        rdc(a[9:0], a == `T1PC_IDX_MASK ? `T1PC_MASK_RST : `T1PC_CTRL_RST);
    end
    idle();
    $display("reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
